// ---- hdl/bmu_unit.sv ----
// Single-bit manipulation unit of the 8-bit core: sequencing, memory
// read-modify-write and flag/register write-back.
// Assumes the decoder, register file and memory port share mclk_in.
`default_nettype none

module bmu_unit (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic start_in,
   input wire bmu_pkg::bmu_op_t op_in,
   input wire logic target_mem_in,
   input wire logic pos_from_reg_in,
   input wire logic [bmu_pkg::BMU_POS_W-1:0] pos_imm_in,
   input wire logic [bmu_pkg::BMU_BYTE_W-1:0] pos_reg_in,
   input wire logic [bmu_pkg::BMU_BYTE_W-1:0] reg_data_in,
   input wire logic [bmu_pkg::BMU_ADDR_W-1:0] mem_addr_in,
   input wire logic carry_in,
   input wire logic mem_rd_ack_in,
   input wire logic [bmu_pkg::BMU_BYTE_W-1:0] mem_rdata_in,
   input wire logic mem_wr_ack_in,
   output logic busy_out,
   output logic done_out,
   output logic reg_wr_out,
   output logic [bmu_pkg::BMU_BYTE_W-1:0] reg_wdata_out,
   output logic carry_out,
   output logic carry_we_out,
   output logic zero_out,
   output logic zero_we_out,
   output logic mem_rd_req_out,
   output logic mem_wr_req_out,
   output logic [bmu_pkg::BMU_ADDR_W-1:0] mem_addr_out,
   output logic [bmu_pkg::BMU_BYTE_W-1:0] mem_wdata_out
);

   // ********************************
   // Declarations
   // ********************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_CALC,
      ST_WRITE
   } bmu_state_t;

   bmu_state_t state_r;
   bmu_state_t state_nxt;
   bmu_pkg::bmu_op_t op_r;
   logic [bmu_pkg::BMU_POS_W-1:0] pos_r;
   logic [bmu_pkg::BMU_POS_W-1:0] pos_nxt;
   logic mem_r;
   logic carry_src_r;
   logic [bmu_pkg::BMU_BYTE_W-1:0] byte_r;
   logic [bmu_pkg::BMU_ADDR_W-1:0] addr_r;
   logic accept;
   logic finish;
   logic [bmu_pkg::BMU_BYTE_W-1:0] core_byte;
   logic core_byte_we;
   logic core_carry;
   logic core_carry_we;
   logic core_zero;
   logic core_zero_we;
   logic done_r;
   logic reg_wr_r;
   logic [bmu_pkg::BMU_BYTE_W-1:0] reg_wdata_r;
   logic carry_r;
   logic carry_we_r;
   logic zero_r;
   logic zero_we_r;
   logic [bmu_pkg::BMU_BYTE_W-1:0] mem_wdata_r;

   // ********************************
   // Request acceptance
   // ********************************
   // A request is only taken while idle; the decoder must hold it until busy drops
   assign accept = start_in && (state_r == ST_IDLE);

   // Inverted ops ignore the register source even if the decoder selects it
   always_comb begin
      if (pos_from_reg_in && !bmu_pkg::bmu_imm_only(op_in)) begin
         pos_nxt = pos_reg_in[bmu_pkg::BMU_POS_W-1:0];
      end else begin
         pos_nxt = pos_imm_in;
      end
   end

   // ********************************
   // Sequencer
   // ********************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (accept) begin
               state_nxt = target_mem_in ? ST_READ : ST_CALC;
            end
         end
         ST_READ: begin
            if (mem_rd_ack_in) begin
               state_nxt = ST_CALC;
            end
         end
         ST_CALC: begin
            state_nxt = (mem_r && core_byte_we) ? ST_WRITE : ST_IDLE;
         end
         ST_WRITE: begin
            if (mem_wr_ack_in) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign finish = ((state_r == ST_CALC) && !(mem_r && core_byte_we)) ||
                   ((state_r == ST_WRITE) && mem_wr_ack_in);

   // ********************************
   // Operand capture
   // ********************************
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         op_r <= bmu_pkg::BMU_BIT_TEST_OP;
         pos_r <= bmu_pkg::BMU_POS_RST;
         mem_r <= bmu_pkg::BMU_FLAG_RST;
         carry_src_r <= bmu_pkg::BMU_FLAG_RST;
         addr_r <= bmu_pkg::BMU_ADDR_RST;
      end else if (accept) begin
         op_r <= op_in;
         pos_r <= pos_nxt;
         mem_r <= target_mem_in;
         carry_src_r <= carry_in;
         addr_r <= mem_addr_in;
      end
   end

   // Whole byte is held so the write-back keeps the other seven bits
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         byte_r <= bmu_pkg::BMU_BYTE_RST;
      end else if (accept && !target_mem_in) begin
         byte_r <= reg_data_in;
      end else if ((state_r == ST_READ) && mem_rd_ack_in) begin
         byte_r <= mem_rdata_in;
      end
   end

   bmu_bit_core u_core (
      .op_in(op_r),
      .byte_in(byte_r),
      .pos_in(pos_r),
      .carry_in(carry_src_r),
      .byte_out(core_byte),
      .byte_we_out(core_byte_we),
      .carry_out(core_carry),
      .carry_we_out(core_carry_we),
      .zero_out(core_zero),
      .zero_we_out(core_zero_we)
   );

   // ********************************
   // Memory write data
   // ********************************
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         mem_wdata_r <= bmu_pkg::BMU_BYTE_RST;
      end else if ((state_r == ST_CALC) && mem_r && core_byte_we) begin
         mem_wdata_r <= core_byte;
      end
   end

   // ********************************
   // Write-back pulses
   // ********************************
   // Flag strobes only for the flag an op names, so the core keeps the rest
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         done_r <= bmu_pkg::BMU_FLAG_RST;
         reg_wr_r <= bmu_pkg::BMU_FLAG_RST;
         carry_we_r <= bmu_pkg::BMU_FLAG_RST;
         zero_we_r <= bmu_pkg::BMU_FLAG_RST;
      end else begin
         done_r <= finish;
         reg_wr_r <= finish && !mem_r && core_byte_we;
         carry_we_r <= finish && core_carry_we;
         zero_we_r <= finish && core_zero_we;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         reg_wdata_r <= bmu_pkg::BMU_BYTE_RST;
         carry_r <= bmu_pkg::BMU_FLAG_RST;
         zero_r <= bmu_pkg::BMU_FLAG_RST;
      end else if (finish) begin
         reg_wdata_r <= core_byte;
         carry_r <= core_carry;
         zero_r <= core_zero;
      end
   end

   assign busy_out = (state_r != ST_IDLE);
   assign done_out = done_r;
   assign reg_wr_out = reg_wr_r;
   assign reg_wdata_out = reg_wdata_r;
   assign carry_out = carry_r;
   assign carry_we_out = carry_we_r;
   assign zero_out = zero_r;
   assign zero_we_out = zero_we_r;
   assign mem_rd_req_out = (state_r == ST_READ);
   assign mem_wr_req_out = (state_r == ST_WRITE);
   assign mem_addr_out = addr_r;
   assign mem_wdata_out = mem_wdata_r;

   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   set_bit_one_a: assert property (
      reg_wr_out && (op_r == bmu_pkg::BMU_BIT_SET_OP) |-> reg_wdata_out[pos_r])
      else $error("set did not force bit to one");

   clear_bit_zero_a: assert property (
      reg_wr_out && (op_r == bmu_pkg::BMU_BIT_CLEAR_OP) |-> !reg_wdata_out[pos_r])
      else $error("clear did not force bit to zero");

   invert_bit_a: assert property (
      reg_wr_out && (op_r == bmu_pkg::BMU_BIT_INVERT_OP)
      |-> reg_wdata_out[pos_r] != byte_r[pos_r])
      else $error("invert did not flip bit");

   other_bits_kept_a: assert property (
      reg_wr_out |-> ((reg_wdata_out ^ byte_r) & ~(8'h01 << pos_r)) == 8'h00)
      else $error("bits other than the chosen one changed");

   test_zero_flag_a: assert property (
      zero_we_out |-> (zero_out == !byte_r[pos_r]) && !carry_we_out && !reg_wr_out)
      else $error("test flag wrong or other flag touched");

   reg_pos_source_a: assert property (
      accept && pos_from_reg_in && !bmu_pkg::bmu_imm_only(op_in)
      |=> pos_r == $past(pos_reg_in[bmu_pkg::BMU_POS_W-1:0]))
      else $error("register bit number not taken");

   imm_only_pos_a: assert property (
      accept && bmu_pkg::bmu_imm_only(op_in) |=> pos_r == $past(pos_imm_in))
      else $error("inverted op took bit number from register");

   carry_and_a: assert property (
      carry_we_out && (op_r == bmu_pkg::BMU_CARRY_AND_BIT_OP)
      |-> carry_out == (carry_src_r & byte_r[pos_r]))
      else $error("carry and result wrong");

   carry_xor_inv_a: assert property (
      carry_we_out && (op_r == bmu_pkg::BMU_CARRY_XOR_INVERTED_BIT_OP)
      |-> carry_out == (carry_src_r ^ !byte_r[pos_r]))
      else $error("inverted carry xor result wrong");

   load_carry_a: assert property (
      done_out && (op_r == bmu_pkg::BMU_BIT_LOAD_TO_CARRY_OP)
      |-> carry_we_out && (carry_out == byte_r[pos_r]) && !reg_wr_out)
      else $error("bit load wrong or source rewritten");

   store_carry_a: assert property (
      reg_wr_out && (op_r == bmu_pkg::BMU_INVERTED_CARRY_STORE_TO_BIT_OP)
      |-> reg_wdata_out[pos_r] == !carry_src_r)
      else $error("inverted store wrong");

   mem_rmw_a: assert property (
      mem_rd_req_out && mem_rd_ack_in && (op_r == bmu_pkg::BMU_BIT_SET_OP)
      ##2 mem_wr_req_out |-> $stable(mem_addr_out)
      && mem_wdata_out == ($past(mem_rdata_in, 2) | (8'h01 << pos_r)))
      else $error("memory write-back not the read byte with one bit changed");

endmodule // bmu_unit

`default_nettype wire

// ---- hdl/bmu_pkg.sv ----
// Shared constants and operation codes of the single-bit manipulation unit.
// Assumes one core clock and a decoder that hands over one operation at a time.
`default_nettype none

package bmu_pkg;

   // ********************************
   // Widths and reset values
   // ********************************
   localparam int BMU_BYTE_W = 8;
   localparam int BMU_POS_W = 3;
   localparam int BMU_ADDR_W = 16;
   localparam logic [BMU_BYTE_W-1:0] BMU_BYTE_RST = 8'h00;
   localparam logic [BMU_POS_W-1:0] BMU_POS_RST = 3'h0;
   localparam logic [BMU_ADDR_W-1:0] BMU_ADDR_RST = 16'h0000;
   localparam logic BMU_FLAG_RST = 1'h0;

   // ********************************
   // Operation codes
   // ********************************
   typedef enum logic [3:0] {
      BMU_BIT_SET_OP,
      BMU_BIT_CLEAR_OP,
      BMU_BIT_INVERT_OP,
      BMU_BIT_TEST_OP,
      BMU_CARRY_AND_BIT_OP,
      BMU_CARRY_AND_INVERTED_BIT_OP,
      BMU_CARRY_OR_BIT_OP,
      BMU_CARRY_OR_INVERTED_BIT_OP,
      BMU_CARRY_XOR_BIT_OP,
      BMU_CARRY_XOR_INVERTED_BIT_OP,
      BMU_BIT_LOAD_TO_CARRY_OP,
      BMU_INVERTED_BIT_LOAD_TO_CARRY_OP,
      BMU_CARRY_STORE_TO_BIT_OP,
      BMU_INVERTED_CARRY_STORE_TO_BIT_OP
   } bmu_op_t;

   // Operations whose bit number may only come from the immediate field
   function automatic logic bmu_imm_only(input bmu_op_t op);
      case (op)
         BMU_CARRY_AND_INVERTED_BIT_OP,
         BMU_CARRY_OR_INVERTED_BIT_OP,
         BMU_CARRY_XOR_INVERTED_BIT_OP,
         BMU_INVERTED_BIT_LOAD_TO_CARRY_OP,
         BMU_INVERTED_CARRY_STORE_TO_BIT_OP: bmu_imm_only = 1'b1;
         default: bmu_imm_only = 1'b0;
      endcase
   endfunction

endpackage : bmu_pkg

`default_nettype wire

// ---- hdl/bmu_bit_core.sv ----
// Combinational bit datapath: new byte, carry and zero for one operation.
// Assumes operands are held stable by the sequencer around it.
`default_nettype none

module bmu_bit_core (
   input wire bmu_pkg::bmu_op_t op_in,
   input wire logic [bmu_pkg::BMU_BYTE_W-1:0] byte_in,
   input wire logic [bmu_pkg::BMU_POS_W-1:0] pos_in,
   input wire logic carry_in,
   output logic [bmu_pkg::BMU_BYTE_W-1:0] byte_out,
   output logic byte_we_out,
   output logic carry_out,
   output logic carry_we_out,
   output logic zero_out,
   output logic zero_we_out
);

   logic sel_bit;
   logic new_bit;

   // ********************************
   // Operation decode
   // ********************************
   assign sel_bit = byte_in[pos_in];

   always_comb begin
      new_bit = sel_bit;
      byte_we_out = 1'b0;
      carry_out = carry_in;
      carry_we_out = 1'b0;
      zero_out = ~sel_bit;
      zero_we_out = 1'b0;
      case (op_in)
         bmu_pkg::BMU_BIT_SET_OP: begin
            new_bit = 1'b1;
            byte_we_out = 1'b1;
         end
         bmu_pkg::BMU_BIT_CLEAR_OP: begin
            new_bit = 1'b0;
            byte_we_out = 1'b1;
         end
         bmu_pkg::BMU_BIT_INVERT_OP: begin
            new_bit = ~sel_bit;
            byte_we_out = 1'b1;
         end
         bmu_pkg::BMU_BIT_TEST_OP: zero_we_out = 1'b1;
         bmu_pkg::BMU_CARRY_AND_BIT_OP: begin
            carry_out = carry_in & sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_CARRY_AND_INVERTED_BIT_OP: begin
            carry_out = carry_in & ~sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_CARRY_OR_BIT_OP: begin
            carry_out = carry_in | sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_CARRY_OR_INVERTED_BIT_OP: begin
            carry_out = carry_in | ~sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_CARRY_XOR_BIT_OP: begin
            carry_out = carry_in ^ sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_CARRY_XOR_INVERTED_BIT_OP: begin
            carry_out = carry_in ^ ~sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_BIT_LOAD_TO_CARRY_OP: begin
            carry_out = sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_INVERTED_BIT_LOAD_TO_CARRY_OP: begin
            carry_out = ~sel_bit;
            carry_we_out = 1'b1;
         end
         bmu_pkg::BMU_CARRY_STORE_TO_BIT_OP: begin
            new_bit = carry_in;
            byte_we_out = 1'b1;
         end
         bmu_pkg::BMU_INVERTED_CARRY_STORE_TO_BIT_OP: begin
            new_bit = ~carry_in;
            byte_we_out = 1'b1;
         end
         default: begin
            new_bit = sel_bit;
         end
      endcase
   end

   // ********************************
   // Per-bit merge
   // ********************************
   // Only the addressed bit takes the new value; the rest pass through
   genvar gi;
   generate
      for (gi = 0; gi < bmu_pkg::BMU_BYTE_W; gi++) begin : g_bit
         assign byte_out[gi] = (int'(pos_in) == gi) ?
                               new_bit : byte_in[gi];
      end
   endgenerate

endmodule // bmu_bit_core

`default_nettype wire

// ---- tb/bmu_mem_model.sv ----
// Memory partner of the bit unit: a 256-byte store that answers each request after a set wait.
// Assumes the unit holds request, address and write data until they are acknowledged.
`default_nettype none

module bmu_mem_model (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic rd_req_in,
   input wire logic wr_req_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [1:0] wait_in,
   output logic rd_ack_out,
   output logic wr_ack_out,
   output logic [7:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // ********************************
   // Store and handshake
   // ********************************
   logic [7:0] mem_r [256];
   logic [7:0] last_r = 8'hA5;
   logic [1:0] cnt_r = 2'h0;
   logic ack;

   assign ack = (rd_req_in || wr_req_in) && (cnt_r == wait_in);
   assign rd_ack_out = rd_req_in && ack;
   assign wr_ack_out = wr_req_in && ack;
   // Scrambled outside an answer, so a late or early sample cannot match by luck
   assign rdata_out = rd_ack_out ? mem_r[addr_in[7:0]] : ~last_r;

   always @(posedge mclk_in) begin
      last_r <= rdata_out;
      if (reset_in || ack) begin
         cnt_r <= 2'h0;
      end else if (rd_req_in || wr_req_in) begin
         cnt_r <= cnt_r + 2'h1;
      end
      if (wr_ack_out) begin
         mem_r[addr_in[7:0]] <= wdata_in;
      end
   end
endmodule // bmu_mem_model

`default_nettype wire

// ---- tb/test_bit_manipulation_unit.sv ----
// Self-checking bench of the bit unit: every operation on register and memory, then random.
// Assumes the memory partner model and the package of the unit are compiled first.
`default_nettype none

module test_bit_manipulation_unit;
   timeunit 1ns;
   timeprecision 1ns;

   // ********************************
   // Stimulus and wiring
   // ********************************
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic start_in = 1'b0;
   bmu_pkg::bmu_op_t op_in = bmu_pkg::BMU_BIT_SET_OP;
   logic target_mem_in = 1'b0;
   logic pos_from_reg_in = 1'b0;
   logic [2:0] pos_imm_in = 3'h0;
   logic [7:0] pos_reg_in = 8'h00;
   logic [7:0] reg_data_in = 8'h00;
   logic [15:0] mem_addr_in = 16'h0000;
   logic carry_in = 1'b0;
   logic [1:0] wait_sel = 2'h0;
   logic rd_ack, wr_ack, busy, done, reg_wr, carry_o, carry_we, zero_o, zero_we, rd_req, wr_req;
   logic [7:0] rdata, reg_wdata, wdata;
   logic [15:0] addr;
   logic [7:0] lfsr_r = 8'h3C;
   int n_mismatch = 0;
   int checks = 0;

   bmu_unit bmu_unit_inst (.mclk_in(mclk_in), .reset_in(reset_in), .start_in(start_in),
      .op_in(op_in), .target_mem_in(target_mem_in), .pos_from_reg_in(pos_from_reg_in),
      .pos_imm_in(pos_imm_in), .pos_reg_in(pos_reg_in), .reg_data_in(reg_data_in),
      .mem_addr_in(mem_addr_in), .carry_in(carry_in), .mem_rd_ack_in(rd_ack),
      .mem_rdata_in(rdata), .mem_wr_ack_in(wr_ack), .busy_out(busy), .done_out(done),
      .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata), .carry_out(carry_o),
      .carry_we_out(carry_we), .zero_out(zero_o), .zero_we_out(zero_we),
      .mem_rd_req_out(rd_req), .mem_wr_req_out(wr_req), .mem_addr_out(addr),
      .mem_wdata_out(wdata));

   bmu_mem_model bmu_mem_model_inst (.mclk_in(mclk_in), .reset_in(reset_in),
      .rd_req_in(rd_req), .wr_req_in(wr_req), .addr_in(addr), .wdata_in(wdata),
      .wait_in(wait_sel), .rd_ack_out(rd_ack), .wr_ack_out(wr_ack), .rdata_out(rdata));

   // ********************************
   // Expectations and comparisons
   // ********************************
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic step(output logic [7:0] v);
      lfsr_r = lfsr_next(lfsr_r);
      v = lfsr_r;
   endtask

   function automatic logic imm_only(input bmu_pkg::bmu_op_t op);
      return op inside {bmu_pkg::BMU_CARRY_AND_INVERTED_BIT_OP, bmu_pkg::BMU_CARRY_OR_INVERTED_BIT_OP,
         bmu_pkg::BMU_CARRY_XOR_INVERTED_BIT_OP, bmu_pkg::BMU_INVERTED_BIT_LOAD_TO_CARRY_OP,
         bmu_pkg::BMU_INVERTED_CARRY_STORE_TO_BIT_OP};
   endfunction

   function automatic void expect_op(input bmu_pkg::bmu_op_t op, input logic [7:0] b,
      input logic [2:0] p, input logic c, output logic [7:0] nb, output logic nc);
      nb = b;
      nc = c;
      case (op)
         bmu_pkg::BMU_BIT_SET_OP: nb[p] = 1'b1;
         bmu_pkg::BMU_BIT_CLEAR_OP: nb[p] = 1'b0;
         bmu_pkg::BMU_BIT_INVERT_OP: nb[p] = ~b[p];
         bmu_pkg::BMU_CARRY_AND_BIT_OP: nc = c & b[p];
         bmu_pkg::BMU_CARRY_AND_INVERTED_BIT_OP: nc = c & ~b[p];
         bmu_pkg::BMU_CARRY_OR_BIT_OP: nc = c | b[p];
         bmu_pkg::BMU_CARRY_OR_INVERTED_BIT_OP: nc = c | ~b[p];
         bmu_pkg::BMU_CARRY_XOR_BIT_OP: nc = c ^ b[p];
         bmu_pkg::BMU_CARRY_XOR_INVERTED_BIT_OP: nc = c ^ ~b[p];
         bmu_pkg::BMU_BIT_LOAD_TO_CARRY_OP: nc = b[p];
         bmu_pkg::BMU_INVERTED_BIT_LOAD_TO_CARRY_OP: nc = ~b[p];
         bmu_pkg::BMU_CARRY_STORE_TO_BIT_OP: nb[p] = c;
         bmu_pkg::BMU_INVERTED_CARRY_STORE_TO_BIT_OP: nb[p] = ~c;
         default: nb = b;
      endcase
   endfunction

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // One operation: present it, wait for completion, compare every result
   task automatic run_op(input bmu_pkg::bmu_op_t op, input logic mem, input logic fr,
      input logic [2:0] imm, input logic [7:0] preg, input logic [7:0] data, input logic c);
      logic [7:0] a, w, src, nb;
      logic [2:0] p;
      logic nc, bw, cw, zw;
      int n;
      step(a);
      step(w);
      @(posedge mclk_in);
      start_in <= 1'b1;
      op_in <= op;
      target_mem_in <= mem;
      pos_from_reg_in <= fr;
      pos_imm_in <= imm;
      pos_reg_in <= preg;
      reg_data_in <= data;
      carry_in <= c;
      mem_addr_in <= {8'h00, a};
      wait_sel <= w[1:0];
      src = mem ? bmu_mem_model_inst.mem_r[a] : data;
      @(posedge mclk_in);
      start_in <= 1'b0;
      n = 0;
      do begin
         @(negedge mclk_in);
         n++;
         if (n == 1) cmp_bit(busy, 1'b1);
      end while (done !== 1'b1 && n < 40);
      p = (fr && !imm_only(op)) ? preg[2:0] : imm;
      expect_op(op, src, p, c, nb, nc);
      bw = op inside {[bmu_pkg::BMU_BIT_SET_OP:bmu_pkg::BMU_BIT_INVERT_OP],
         bmu_pkg::BMU_CARRY_STORE_TO_BIT_OP, bmu_pkg::BMU_INVERTED_CARRY_STORE_TO_BIT_OP};
      cw = op inside {[bmu_pkg::BMU_CARRY_AND_BIT_OP:bmu_pkg::BMU_INVERTED_BIT_LOAD_TO_CARRY_OP]};
      zw = (op == bmu_pkg::BMU_BIT_TEST_OP);
      cmp_bit(done, 1'b1);
      cmp_bit(busy, 1'b0);
      cmp_bit(carry_we, cw);
      cmp_bit(zero_we, zw);
      cmp_bit(reg_wr, bw & !mem);
      if (cw) cmp_bit(carry_o, nc);
      if (zw) cmp_bit(zero_o, ~src[p]);
      if (bw && !mem) cmp_byte(reg_wdata, nb);
      if (mem) cmp_byte(bmu_mem_model_inst.mem_r[a], nb);
   endtask

   task automatic results();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ********************************
   // Clock, watchdog and main sequence
   // ********************************
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end

   // Some 330 operations of at most 15 cycles each fit well inside this span
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      results();
   end

   initial begin
      logic [7:0] r0, r1, r2;
      for (int i = 0; i < 256; i++) begin
         step(r0);
         bmu_mem_model_inst.mem_r[i] = r0;
      end
      repeat (12) @(posedge mclk_in);
      reset_in <= 1'b0;
      // Register picks bit 0, immediate picks bit 7: immediate-only ops must use bit 7
      for (int i = 0; i < 14; i++) begin
         run_op(bmu_pkg::bmu_op_t'(i), 1'b0, 1'b1, 3'h7, 8'hF8, 8'h80, 1'b1);
         run_op(bmu_pkg::bmu_op_t'(i), 1'b1, 1'b0, 3'h0, 8'h07, 8'h00, 1'b0);
      end
      for (int i = 0; i < 300; i++) begin
         step(r0);
         step(r1);
         step(r2);
         run_op(bmu_pkg::bmu_op_t'(4'(r0 % 8'h0E)), r0[7], r1[0], r1[3:1], r2, r1 ^ r2,
            r0[4]);
      end
      results();
   end
endmodule // test_bit_manipulation_unit

`default_nettype wire
